// ===== pkg/crg_pkg.sv
// Constants and types of the clock and reset generator
package crg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_MULT = 4'h0;
  localparam logic [3:0] IDX_REFDIV = 4'h1;
  localparam logic [3:0] IDX_TFLAG = 4'h2;
  localparam logic [3:0] IDX_FLAGS = 4'h3;
  localparam logic [3:0] IDX_INTEN = 4'h4;
  localparam logic [3:0] IDX_CLOCK_SELECT = 4'h5;
  localparam logic [3:0] IDX_LOOPCTL = 4'h6;
  localparam logic [3:0] IDX_PERCTL = 4'h7;
  localparam logic [3:0] IDX_WDGCTL = 4'h8;
  localparam logic [3:0] IDX_FBTEST = 4'h9;
  localparam logic [3:0] IDX_TCTL = 4'hA;
  localparam logic [3:0] IDX_SERVICE = 4'hB;
  // Status flag bits, shared with the interrupt enable layout
  localparam int FLG_PER = 7;
  localparam int FLG_POR = 6;
  localparam int FLG_LVR = 5;
  localparam int FLG_LOCKI = 4;
  localparam int FLG_LOCK = 3;
  localparam int FLG_TRACK = 2;
  localparam int FLG_SELFI = 1;
  localparam int FLG_SELF = 0;
  localparam logic [7:0] FLAG_W1C_MASK = 8'hF2;
  localparam logic [7:0] INTEN_MASK = 8'h92;
  // Clock select bits
  localparam int SEL_LOOP = 7;
  localparam int SEL_PSTOP = 6;
  localparam int SEL_SYSWAI = 5;
  localparam int SEL_LOOPWAI = 3;
  localparam int SEL_COREWAI = 2;
  localparam int SEL_PERWAI = 1;
  localparam int SEL_WDGWAI = 0;
  // Loop control bits
  localparam int LC_CMON = 7;
  localparam int LC_ON = 6;
  localparam int LC_PER_PSTOP = 2;
  localparam int LC_WDG_PSTOP = 1;
  localparam int LC_SELFCLK = 0;
  localparam logic [7:0] LOOPCTL_MASK = 8'hF7;
  localparam logic [7:0] LOOPCTL_RESET = 8'hF1;
  // Watchdog control and service
  localparam int WDG_WINDOW = 7;
  localparam logic [7:0] WDGCTL_MASK = 8'hC7;
  localparam logic [7:0] SERVICE_ARM = 8'h55;
  localparam logic [7:0] SERVICE_CLEAR = 8'hAA;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_PULSE_NS = 800;
  localparam logic [4:0] RESET_PULSE_CYCLES = 5'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] LOCK_INIT_CYCLES = 4'h8;
  localparam int PER_BASE_SHIFT = 9;
  // Synchroniser lanes
  localparam int SY_LOSS = 0;
  localparam int SY_QOK = 1;
  localparam int SY_LOCK = 2;
  localparam int SY_TRACK = 3;
  localparam int SY_PIN = 4;
  localparam int SY_POR = 5;
  localparam int SY_LVR = 6;
  localparam logic [6:0] SYNC_INIT = 7'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    MODE_RUN = 4'b0001,
    MODE_WAIT = 4'b0010,
    MODE_FSTOP = 4'b0100,
    MODE_PSTOP = 4'b1000
  } power_mode_e;
endpackage

// ===== verilog/clock_reset_generator.sv
// Clock and reset generator with AXI4-Lite register slave
//
// Contract
// - In wait mode gate system and core clocks per clock select bits.
// - Stop entry gives full stop when pseudo-stop bit is 0, else pseudo-stop.
// - Full stop disables oscillator, stops clocks, freezes watchdog and periodic counters.
// - Pseudo-stop keeps oscillator; counters run only if their enable is set.
// - Self-clock entered only with monitor, fallback enabled and reference lost.
// - Self-clock stays until the clock quality check passes.
// - Reset pin active low, input resets, device drives it low on internal reset.
// - System reset from power-on, low voltage, watchdog, clock loss, reset pin.
// - Lock change in either direction raises the lock interrupt flag.
// - Watchdog service writes are honoured only inside the clear window.
// - Software switches system clock between oscillator and loop clock.
// - Twelve byte registers, one per word, at offsets 0x00 to 0x2C from a base.
// - Test registers read zero and never affect normal operation.
// - Loop clock is 2*osc*(mult+1)/(div+1); bus is half the loop clock.
// - Multiplier and divider writes ignored while loop selected; writes restart lock.
// - Event flags clear only on writing one; zero leaves them.
`timescale 1ns/10ps
module clock_reset_generator
  import crg_pkg::*;
#(
  parameter int unsigned WDG_BASE_CYCLES = 8192
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Oscillator and loop status
  input wire logic osc_loss,
  input wire logic quality_ok,
  input wire logic lock_in,
  input wire logic track_in,
  // Reset sources
  input wire logic reset_pin_in_n,
  input wire logic por_event,
  input wire logic lvr_event,
  // Power mode requests
  input wire logic wait_req,
  input wire logic stop_req,
  // Clock control
  output logic osc_enable,
  output logic sys_clk_en,
  output logic core_clk_en,
  output logic loop_clk_en,
  output logic loop_clock_select,
  output logic self_clock_status,
  output logic [5:0] pll_multiplier,
  output logic [3:0] reference_divider,
  // Reset and interrupt
  output logic sys_reset,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic irq
);

  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic awheld;
    logic wheld;
    logic [7:0] awaddr;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [5:0] mult;
    logic [3:0] refdiv;
    logic [7:0] flags;
    logic [7:0] inten;
    logic [7:0] clock_select;
    logic [7:0] loopctl;
    logic [6:0] perctl;
    logic [7:0] wdgctl;
    logic armed;
    power_mode_e mode;
    logic selfclk;
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] filt;
    logic [3:0] lock_init;
    logic [23:0] per_cnt;
    logic [25:0] wdg_cnt;
    logic [4:0] rst_cnt;
    logic rst_drive;
    logic sys_rst;
    logic osc_en;
    logic sys_en;
    logic core_en;
    logic loop_en;
    logic loop_sel;
    logic irq;
  } state_s;

  state_s r_reg;
  state_s r_next;
  logic [6:0] agree;
  logic [7:0] rd_byte;
  logic wr_en;
  logic [7:0] wbyte;
  logic wdg_on;
  logic per_on;
  logic per_run;
  logic wdg_run;
  logic per_tick;
  logic wdg_tout;
  logic in_window;
  logic svc_bad;
  logic svc_early;
  logic clk_loss_rst;
  logic int_src;
  logic ext_rst;
  logic lock_now;
  logic track_now;
  logic [23:0] per_limit;
  logic [25:0] wdg_limit;

  function automatic logic addr_ok(input logic [7:0] a);
    return a[1:0] == 2'b00 && a[7:6] == 2'b00 && a[5:2] <= IDX_SERVICE;
  endfunction

  always_comb
  begin
    r_next = r_reg;
    // Pin inputs: a change counts once stages two and three agree
    agree = ~(r_reg.s2 ^ r_reg.s3);
    r_next.s1 = {lvr_event, por_event, reset_pin_in_n, track_in, lock_in, quality_ok, osc_loss};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.filt = (r_reg.s2 & agree) | (r_reg.filt & ~agree);

    // Read mux
    case (araddr[5:2])
      IDX_MULT: rd_byte = {2'b00, r_reg.mult};
      IDX_REFDIV: rd_byte = {4'h0, r_reg.refdiv};
      IDX_FLAGS: rd_byte = r_reg.flags;
      IDX_INTEN: rd_byte = r_reg.inten;
      IDX_CLOCK_SELECT: rd_byte = r_reg.clock_select;
      IDX_LOOPCTL: rd_byte = r_reg.loopctl;
      IDX_PERCTL: rd_byte = {1'b0, r_reg.perctl};
      IDX_WDGCTL: rd_byte = r_reg.wdgctl;
      default: rd_byte = 8'h00;
    endcase

    // Bus slave
    wr_en = 1'b0;
    wbyte = r_reg.wbyte;
    if (r_reg.aw_rdy && awvalid)
    begin
      r_next.awheld = 1'b1;
      r_next.awaddr = awaddr;
    end
    if (r_reg.w_rdy && wvalid)
    begin
      r_next.wheld = 1'b1;
      r_next.wbyte = wdata[7:0];
      r_next.wlane = wstrb[0];
    end
    if (r_reg.bvalid && bready)
      r_next.bvalid = 1'b0;
    if (r_reg.awheld && r_reg.wheld && !r_reg.bvalid)
    begin
      r_next.awheld = 1'b0;
      r_next.wheld = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = addr_ok(r_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
      wr_en = addr_ok(r_reg.awaddr) && r_reg.wlane;
    end
    r_next.aw_rdy = !r_next.awheld && !r_next.bvalid;
    r_next.w_rdy = !r_next.wheld && !r_next.bvalid;
    if (r_reg.rvalid && rready)
      r_next.rvalid = 1'b0;
    if (r_reg.ar_rdy && arvalid)
    begin
      r_next.rvalid = 1'b1;
      r_next.rresp = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      r_next.rdata = addr_ok(araddr) ? rd_byte : 8'h00;
    end
    r_next.ar_rdy = !r_next.rvalid;

    // Self-clock fallback
    clk_loss_rst = 1'b0;
    if (!r_reg.selfclk && r_reg.loopctl[LC_CMON] && r_reg.loopctl[LC_SELFCLK] && r_reg.filt[SY_LOSS])
      r_next.selfclk = 1'b1;
    else if (r_reg.selfclk && r_reg.filt[SY_QOK])
      r_next.selfclk = 1'b0;
    if (!r_reg.selfclk && r_reg.loopctl[LC_CMON] && !r_reg.loopctl[LC_SELFCLK] && r_reg.filt[SY_LOSS])
      clk_loss_rst = 1'b1;
    if (r_reg.lock_init != 4'h0)
      r_next.lock_init = r_reg.lock_init - 4'h1;

    // Periodic interrupt and watchdog counters
    per_on = r_reg.perctl[6:4] != 3'b000;
    wdg_on = r_reg.wdgctl[2:0] != 3'b000;
    per_limit = 24'(({20'h0, r_reg.perctl[3:0]} + 24'h1) << (PER_BASE_SHIFT + int'(r_reg.perctl[6:4])));
    wdg_limit = 26'(WDG_BASE_CYCLES) << {r_reg.wdgctl[2:0] - 3'h1, 1'b0};
    per_run = per_on && r_reg.mode != MODE_FSTOP
      && !(r_reg.mode == MODE_PSTOP && !r_reg.loopctl[LC_PER_PSTOP])
      && !(r_reg.mode == MODE_WAIT && r_reg.clock_select[SEL_PERWAI]);
    wdg_run = wdg_on && r_reg.mode != MODE_FSTOP
      && !(r_reg.mode == MODE_PSTOP && !r_reg.loopctl[LC_WDG_PSTOP])
      && !(r_reg.mode == MODE_WAIT && r_reg.clock_select[SEL_WDGWAI]);
    per_tick = 1'b0;
    wdg_tout = 1'b0;
    if (per_run)
    begin
      if (r_reg.per_cnt >= per_limit - 24'h1)
      begin
        r_next.per_cnt = '0;
        per_tick = 1'b1;
      end
      else
        r_next.per_cnt = r_reg.per_cnt + 24'h1;
    end
    if (wdg_run)
    begin
      if (r_reg.wdg_cnt >= wdg_limit - 26'h1)
      begin
        r_next.wdg_cnt = '0;
        wdg_tout = 1'b1;
      end
      else
        r_next.wdg_cnt = r_reg.wdg_cnt + 26'h1;
    end
    // Window is the last quarter of the period
    in_window = !r_reg.wdgctl[WDG_WINDOW] || r_reg.wdg_cnt >= wdg_limit - (wdg_limit >> 2);

    // Register writes
    svc_bad = 1'b0;
    svc_early = 1'b0;
    if (wr_en)
    begin
      case (r_reg.awaddr[5:2])
        IDX_MULT:
          if (!r_reg.clock_select[SEL_LOOP])
          begin
            r_next.mult = wbyte[5:0];
            r_next.lock_init = LOCK_INIT_CYCLES;
          end
        IDX_REFDIV:
          if (!r_reg.clock_select[SEL_LOOP])
          begin
            r_next.refdiv = wbyte[3:0];
            r_next.lock_init = LOCK_INIT_CYCLES;
          end
        IDX_FLAGS: r_next.flags = r_reg.flags & ~(wbyte & FLAG_W1C_MASK);
        IDX_INTEN: r_next.inten = wbyte & INTEN_MASK;
        IDX_CLOCK_SELECT: r_next.clock_select = wbyte;
        IDX_LOOPCTL: r_next.loopctl = wbyte & LOOPCTL_MASK;
        IDX_PERCTL: r_next.perctl = wbyte[6:0];
        IDX_WDGCTL: r_next.wdgctl = wbyte & WDGCTL_MASK;
        IDX_SERVICE:
          if (wdg_on)
          begin
            if (wbyte == SERVICE_ARM)
            begin
              r_next.armed = 1'b1;
              svc_early = !in_window;
            end
            else if (wbyte == SERVICE_CLEAR && r_reg.armed)
            begin
              r_next.armed = 1'b0;
              r_next.wdg_cnt = '0;
            end
            else
              svc_bad = 1'b1;
          end
        default: ;
      endcase
    end

    // Status and sticky flags; a set wins over a clear
    lock_now = r_reg.filt[SY_LOCK] && !r_next.selfclk && r_next.lock_init == 4'h0;
    track_now = r_reg.filt[SY_TRACK] && !r_next.selfclk && r_next.lock_init == 4'h0;
    r_next.flags[FLG_LOCKI] = r_next.flags[FLG_LOCKI] | (lock_now != r_reg.flags[FLG_LOCK]);
    r_next.flags[FLG_SELFI] = r_next.flags[FLG_SELFI] | (r_next.selfclk != r_reg.selfclk);
    r_next.flags[FLG_PER] = r_next.flags[FLG_PER] | per_tick;
    r_next.flags[FLG_POR] = r_next.flags[FLG_POR] | r_reg.filt[SY_POR];
    r_next.flags[FLG_LVR] = r_next.flags[FLG_LVR] | r_reg.filt[SY_LVR];
    r_next.flags[FLG_LOCK] = lock_now;
    r_next.flags[FLG_TRACK] = track_now;
    r_next.flags[FLG_SELF] = r_next.selfclk;

    // System reset and reset pin
    int_src = r_reg.filt[SY_POR] || r_reg.filt[SY_LVR] || wdg_tout || svc_bad || svc_early || clk_loss_rst;
    ext_rst = !r_reg.filt[SY_PIN] && !r_reg.rst_drive;
    if (int_src)
    begin
      r_next.rst_cnt = RESET_PULSE_CYCLES;
      r_next.rst_drive = 1'b1;
    end
    else if (ext_rst)
      r_next.rst_cnt = RESET_PULSE_CYCLES;
    else if (r_reg.rst_cnt != 5'h00)
      r_next.rst_cnt = r_reg.rst_cnt - 5'h01;
    if (!int_src && r_next.rst_cnt == 5'h00)
      r_next.rst_drive = 1'b0;
    r_next.sys_rst = r_next.rst_cnt != 5'h00;

    // Power mode
    unique case (r_reg.mode)
      MODE_RUN:
        if (stop_req)
          r_next.mode = r_reg.clock_select[SEL_PSTOP] ? MODE_PSTOP : MODE_FSTOP;
        else if (wait_req)
          r_next.mode = MODE_WAIT;
      MODE_WAIT:
        if (!wait_req)
          r_next.mode = MODE_RUN;
      MODE_FSTOP, MODE_PSTOP:
        if (!stop_req)
          r_next.mode = MODE_RUN;
      default: r_next.mode = MODE_RUN;
    endcase

    // Clock gating
    r_next.osc_en = r_next.mode != MODE_FSTOP;
    r_next.sys_en = r_next.mode == MODE_RUN || (r_next.mode == MODE_WAIT && !r_next.clock_select[SEL_SYSWAI]);
    r_next.core_en = r_next.mode == MODE_RUN || (r_next.mode == MODE_WAIT && !r_next.clock_select[SEL_COREWAI]);
    r_next.loop_en = r_next.loopctl[LC_ON]
      && (r_next.mode == MODE_RUN || (r_next.mode == MODE_WAIT && !r_next.clock_select[SEL_LOOPWAI]));
    // Bus clock is the loop clock halved outside this block
    r_next.loop_sel = r_next.clock_select[SEL_LOOP] && !r_next.selfclk;
    r_next.irq = |(r_next.flags & r_next.inten);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg <= '0;
      r_reg.aw_rdy <= 1'b1;
      r_reg.w_rdy <= 1'b1;
      r_reg.ar_rdy <= 1'b1;
      r_reg.loopctl <= LOOPCTL_RESET;
      r_reg.mode <= MODE_RUN;
      r_reg.s1 <= SYNC_INIT;
      r_reg.s2 <= SYNC_INIT;
      r_reg.s3 <= SYNC_INIT;
      r_reg.filt <= SYNC_INIT;
      r_reg.osc_en <= 1'b1;
      r_reg.sys_en <= 1'b1;
      r_reg.core_en <= 1'b1;
      r_reg.loop_en <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign awready = r_reg.aw_rdy;
  assign wready = r_reg.w_rdy;
  assign bvalid = r_reg.bvalid;
  assign bresp = r_reg.bresp;
  assign arready = r_reg.ar_rdy;
  assign rvalid = r_reg.rvalid;
  assign rdata = {24'h0, r_reg.rdata};
  assign rresp = r_reg.rresp;
  assign osc_enable = r_reg.osc_en;
  assign sys_clk_en = r_reg.sys_en;
  assign core_clk_en = r_reg.core_en;
  assign loop_clk_en = r_reg.loop_en;
  assign loop_clock_select = r_reg.loop_sel;
  assign self_clock_status = r_reg.selfclk;
  assign pll_multiplier = r_reg.mult;
  assign reference_divider = r_reg.refdiv;
  assign sys_reset = r_reg.sys_rst;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = r_reg.rst_drive;
  assign irq = r_reg.irq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  fstop_gating_a: assert property (r_reg.mode == MODE_FSTOP |-> !osc_enable && !sys_clk_en && !core_clk_en)
    else $error("Clocks running in full stop");
  fstop_freeze_a: assert property (r_reg.mode == MODE_FSTOP |=> r_reg.wdg_cnt == $past(r_reg.wdg_cnt))
    else $error("Watchdog moved in full stop");
  pstop_keep_a: assert property (r_reg.mode == MODE_PSTOP |-> osc_enable && !core_clk_en)
    else $error("Pseudo-stop gating wrong");
  pstop_per_a: assert property (r_reg.mode == MODE_PSTOP && !r_reg.loopctl[LC_PER_PSTOP] |=> $stable(r_reg.per_cnt))
    else $error("Periodic counter moved in pseudo-stop");
  wait_gate_a: assert property (r_reg.mode == MODE_WAIT && r_reg.clock_select[SEL_SYSWAI] |-> !sys_clk_en)
    else $error("System clock on in wait");
  stop_select_a: assert property (r_reg.mode == MODE_RUN && stop_req |=>
    r_reg.mode == ($past(r_reg.clock_select[SEL_PSTOP]) ? MODE_PSTOP : MODE_FSTOP))
    else $error("Wrong stop mode");
  selfclk_entry_a: assert property ($rose(r_reg.selfclk) |->
    $past(r_reg.loopctl[LC_CMON] && r_reg.loopctl[LC_SELFCLK] && r_reg.filt[SY_LOSS]))
    else $error("Self-clock without cause");
  selfclk_hold_a: assert property (r_reg.selfclk && !r_reg.filt[SY_QOK] |=> r_reg.selfclk)
    else $error("Self-clock left early");
  pin_drive_a: assert property ($rose(reset_pin_oe) |-> ##1 sys_reset [*8])
    else $error("Pin driven without reset pulse");
  lock_flag_a: assert property ($changed(r_reg.flags[FLG_LOCK]) |-> r_reg.flags[FLG_LOCKI])
    else $error("Lock change not flagged");
  selfclk_lock_a: assert property (r_reg.selfclk |-> !r_reg.flags[FLG_LOCK] && !r_reg.flags[FLG_TRACK])
    else $error("Lock shown in self-clock");
  early_service_a: assert property (svc_early |=> sys_reset && reset_pin_oe)
    else $error("Early service not punished");

  mode_pstop_c: cover property (r_reg.mode == MODE_PSTOP);
  selfclk_c: cover property ($rose(r_reg.selfclk));
  wdg_reset_c: cover property (wdg_tout);
  per_irq_c: cover property (per_tick && r_reg.inten[FLG_PER]);

endmodule

// ===== verification/osc_board_model.sv
// Oscillator reference and board reset circuitry model
`timescale 1ns/10ps
module osc_board_model
(
  // Bench controls
  input wire logic aclk,
  input wire logic loss_cmd,
  input wire logic lock_cmd,
  input wire logic pin_low_cmd,
  input wire logic por_cmd,
  // Device side
  input wire logic reset_pin_oe,
  output logic osc_loss,
  output logic quality_ok,
  output logic lock_in,
  output logic track_in,
  output logic reset_pin_in_n,
  output logic por_event
);
  logic [2:0] good_cnt = 3'h0;
  assign osc_loss = loss_cmd;
  // Quality passes only some cycles after the reference returns
  always @(posedge aclk)
    good_cnt <= loss_cmd ? 3'h0 : (good_cnt == 3'h7 ? good_cnt : good_cnt + 3'h1);
  assign quality_ok = (good_cnt == 3'h7);
  assign lock_in = lock_cmd & ~loss_cmd;
  assign track_in = lock_in;
  // Pulled-up pin, low while either party pulls it
  assign reset_pin_in_n = ~(reset_pin_oe | pin_low_cmd);
  assign por_event = por_cmd;
endmodule

// ===== verification/clock_reset_generator_tb.sv
// Self-checking bench of the clock and reset generator
`timescale 1ns/10ps
module clock_reset_generator_tb;
  import crg_pkg::*;
  localparam int WDG = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wait_req = 1'b0, stop_req = 1'b0, loss_cmd = 1'b0, lock_cmd = 1'b0, pin_low_cmd = 1'b0, por_cmd = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, osc_enable, sys_clk_en, core_clk_en, loop_clk_en;
  logic loop_clock_select, self_clock_status, sys_reset, reset_pin_out, reset_pin_oe, irq;
  logic osc_loss, quality_ok, lock_in, track_in, reset_pin_in_n, por_event;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [5:0] pll_multiplier;
  logic [3:0] reference_divider, idx;
  logic [7:0] v, em;
  logic [3:0] tbl [7] = '{IDX_MULT, IDX_REFDIV, IDX_TFLAG, IDX_PERCTL, IDX_FBTEST, IDX_TCTL, IDX_SERVICE};
  int miscompares = 0, n_checks = 0, cyc = 0, rst_cnt = 0, n;

  clock_reset_generator #(.WDG_BASE_CYCLES(WDG)) dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .osc_loss, .quality_ok, .lock_in, .track_in, .reset_pin_in_n, .por_event, .lvr_event(1'b0),
    .wait_req, .stop_req, .osc_enable, .sys_clk_en, .core_clk_en, .loop_clk_en, .loop_clock_select,
    .self_clock_status, .pll_multiplier, .reference_divider, .sys_reset, .reset_pin_out, .reset_pin_oe, .irq);

  osc_board_model partner (.aclk, .loss_cmd, .lock_cmd, .pin_low_cmd, .por_cmd, .reset_pin_oe, .osc_loss,
    .quality_ok, .lock_in, .track_in, .reset_pin_in_n, .por_event);

  always #25 aclk = ~aclk;

  always @(posedge aclk)
  begin
    cyc++;
    if (sys_reset === 1'b1) rst_cnt++;
    if (cyc == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Read-back mask of each register in the random test table
  function automatic logic [7:0] wmask(input logic [3:0] i);
    case (i)
      IDX_MULT: return 8'h3f;
      IDX_REFDIV: return 8'h0f;
      IDX_PERCTL: return 8'h7f;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic pick(input int s);
    case (s)
      0: return irq;
      1: return sys_reset;
      default: return self_clock_status;
    endcase
  endfunction

  // Wait up to n cycles for a watched output to reach a level
  task automatic wt(input int s, input logic lv, input int cnt);
    for (int i = 0; i < cnt && pick(s) !== lv; i++) @(posedge aclk);
  endtask

  // Handshakes are judged on values settled at the falling edge, ahead of the rising edge that takes them
  task automatic wr(input logic [3:0] i, input logic [7:0] val);
    logic a;
    logic w;
    logic b;
    @(posedge aclk);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h00_0000, val};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] i);
    logic a;
    logic b;
    @(posedge aclk);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      a = arvalid && arready;
      b = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (b) break;
    end
    rready <= 1'b0;
  endtask

  initial
  begin
    void'($urandom(32'h65da));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_LOOPCTL);
    chk(d, 32'h0000_00f1);
    rd(4'hc);
    chk(32'(r), 32'(RESP_SLVERR));
    em = 8'h00;
    for (int k = 0; k < 24; k++)
    begin
      idx = tbl[$urandom_range(6)];
      v = 8'($urandom);
      wr(idx, v);
      rd(idx);
      chk(d, {24'h00_0000, v & wmask(idx)});
      if (idx == IDX_MULT) em = v & 8'h3f;
    end
    chk(32'(pll_multiplier), 32'(em));
    wr(IDX_PERCTL, 8'h00);
    wr(IDX_MULT, 8'h05);
    wr(IDX_CLOCK_SELECT, 8'h80);
    @(posedge aclk);
    chk(32'(loop_clock_select), 1);
    wr(IDX_MULT, 8'h2a);
    rd(IDX_MULT);
    chk(d, 32'h0000_0005);
    wr(IDX_CLOCK_SELECT, 8'h00);
    @(posedge aclk);
    chk(32'(loop_clock_select), 0);
    // Lock change interrupt, masked and cleared
    repeat (12) @(posedge aclk);
    wr(IDX_FLAGS, 8'hff);
    wr(IDX_INTEN, 8'h10);
    lock_cmd <= 1'b1;
    wt(0, 1'b1, 20);
    chk(32'(irq), 1);
    rd(IDX_FLAGS);
    chk(32'(d[4:3]), 32'h3);
    wr(IDX_FLAGS, 8'h00);
    rd(IDX_FLAGS);
    chk(32'(d[4]), 1);
    wr(IDX_FLAGS, 8'h10);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 0);
    lock_cmd <= 1'b0;
    wt(0, 1'b1, 20);
    chk(32'(irq), 1);
    wr(IDX_INTEN, 8'h00);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 0);
    wr(IDX_FLAGS, 8'hff);
    // Periodic interrupt, prescale 1, modulus 0
    wr(IDX_INTEN, 8'h80);
    wr(IDX_PERCTL, 8'h10);
    wt(0, 1'b1, 1100);
    chk(32'(irq), 1);
    wr(IDX_PERCTL, 8'h00);
    wr(IDX_FLAGS, 8'h80);
    wr(IDX_INTEN, 8'h00);
    // Self-clock on reference loss
    lock_cmd <= 1'b1;
    loss_cmd <= 1'b1;
    wt(2, 1'b1, 20);
    chk(32'(self_clock_status), 1);
    rd(IDX_FLAGS);
    chk(32'({d[3:2], d[1]}), 32'h1);
    loss_cmd <= 1'b0;
    repeat (5) @(posedge aclk);
    chk(32'(self_clock_status), 1);
    wt(2, 1'b0, 30);
    chk(32'(self_clock_status), 0);
    wr(IDX_LOOPCTL, 8'h41);
    loss_cmd <= 1'b1;
    repeat (12) @(posedge aclk);
    chk(32'(self_clock_status), 0);
    loss_cmd <= 1'b0;
    repeat (12) @(posedge aclk);
    wr(IDX_LOOPCTL, 8'hf1);
    // Wait and stop gating
    wr(IDX_CLOCK_SELECT, 8'h24);
    wait_req <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'({sys_clk_en, core_clk_en, osc_enable}), 32'h1);
    wait_req <= 1'b0;
    wr(IDX_CLOCK_SELECT, 8'h00);
    stop_req <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'({osc_enable, sys_clk_en, core_clk_en}), 32'h0);
    stop_req <= 1'b0;
    wr(IDX_CLOCK_SELECT, 8'h40);
    stop_req <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'({osc_enable, core_clk_en}), 32'h2);
    stop_req <= 1'b0;
    wr(IDX_CLOCK_SELECT, 8'h00);
    // Watchdog time-out, service and window
    wr(IDX_WDGCTL, 8'h01);
    wt(1, 1'b1, 60);
    chk(32'({sys_reset, reset_pin_oe}), 32'h3);
    wr(IDX_WDGCTL, 8'h00);
    repeat (40) @(posedge aclk);
    n = rst_cnt;
    repeat (200) @(posedge aclk);
    chk(32'(rst_cnt - n), 0);
    wr(IDX_WDGCTL, 8'h02);
    n = rst_cnt;
    repeat (6)
    begin
      wr(IDX_SERVICE, SERVICE_ARM);
      wr(IDX_SERVICE, SERVICE_CLEAR);
      repeat (20) @(posedge aclk);
    end
    chk(32'(rst_cnt - n), 0);
    wr(IDX_WDGCTL, 8'h82);
    wr(IDX_SERVICE, SERVICE_ARM);
    wt(1, 1'b1, 20);
    chk(32'(sys_reset), 1);
    wr(IDX_WDGCTL, 8'h00);
    repeat (40) @(posedge aclk);
    // Power-on and pin resets
    por_cmd <= 1'b1;
    repeat (4) @(posedge aclk);
    por_cmd <= 1'b0;
    wt(1, 1'b1, 20);
    chk(32'({sys_reset, reset_pin_oe}), 32'h3);
    repeat (30) @(posedge aclk);
    rd(IDX_FLAGS);
    chk(32'(d[6]), 1);
    pin_low_cmd <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(reset_pin_oe), 0);
    pin_low_cmd <= 1'b0;
    wt(1, 1'b1, 40);
    chk(32'({sys_reset, reset_pin_oe}), 32'h2);
    report_and_stop();
  end
endmodule
